//--- design/spm_serial_master.sv
// Summary of operation
// - a 92-byte store, loaded from the nonvolatile image, feeds the parallel output
// - outside long pattern, each pattern clock rising edge advances to and drives the next stored byte
// - sequencer bytes and virtual input bits share the one set of output lines
// - pattern hold low shows the initial value; high shows the user pattern
// - wrap mode cycles the store; stop-at-end mode holds the last byte
// - long pattern serialises each byte through an eight-input bit multiplexer
// - the byte position counter tracks 92 byte positions of the long pattern
// - a 3-bit counter drives the bit multiplexer select lines
// - one channel marks the ninth scl clock where acknowledge is sampled
// - a missing acknowledge stops the i2c transmission
// - read data is compared against a rotating reference; result held till next read
// - two select lines pick one of four channels onto sda
// - i2c and spi commands start only from the deglitched trigger; the long pattern starts from long enable
// - spi run enable set by trigger, cleared by chip-select rising edge
// - write commands may carry one byte or several consecutive bytes
// - four chained shift registers recirculate a pattern of up to 32 bits
// - the shift clock is driven out so the receiver can delimit bits
module spm_serial_master (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic link_clk_in,
  input wire logic trig_in,
  input wire logic pattern_hold_low_in,
  input wire logic long_enable_in,
  input wire logic [1:0] app_mode_in,
  input wire logic stop_at_end_mode_in,
  input wire logic [1:0] mux_select_in,
  input wire logic [7:0] ref_byte_in,
  input wire logic virt_sel_in,
  input wire logic [7:0] virt_bits_in,
  input wire logic load_we_in,
  input wire logic [6:0] load_addr_in,
  input wire logic [7:0] load_data_in,
  input wire logic sda_in,
  input wire logic shr_clear_in,
  input wire logic shr_start_in,
  input wire logic shr_load_in,
  input wire logic [31:0] shr_seed_in,
  output logic [7:0] pattern_byte_out,
  output logic long_serial_out,
  output logic sda_out,
  output logic sda_oe_out,
  output logic busy_out,
  output logic ack_fail_out,
  output logic cmp_ok_out,
  output logic shr_data_out,
  output logic shr_clk_out
);
  typedef struct packed {
    logic trig_s1;
    logic trig_s2;
    logic hold_s1;
    logic hold_s2;
    logic len_s1;
    logic len_s2;
    logic sda_s1;
    logic sda_s2;
    logic [4:0] deg_cnt;
    logic trig_clean;
    logic trig_clean_d;
    logic [6:0] div_cnt;
    logic tick;
    spm_pkg::spm_state_type state;
    spm_pkg::spm_app_type app;
    logic [6:0] ptr;
    logic [6:0] byte_pos;
    logic [2:0] bit_sel;
    logic [7:0] out_byte;
    logic [7:0] bus_byte;
    logic [7:0] ref_sr;
    logic ser_out;
    logic sda_oe;
    logic cs_d;
    logic ack_fail;
    logic cmp_ok;
    logic shr_clr;
    logic shr_go;
    logic [31:0] seed;
    logic req_tgl;
    logic busy;
  } spm_core_type;

  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic clr_s1;
    logic clr_s2;
    logic go_s1;
    logic go_s2;
    logic req_s1;
    logic req_s2;
    logic req_s3;
    logic phase;
    logic dout;
    logic [3:0][7:0] chain;
  } spm_link_type;

  spm_core_type s_r;
  spm_core_type s_nxt;
  spm_link_type l_r;
  spm_link_type l_nxt;
  logic [7:0] rd_data;

  // sda channel chosen by the two select lines
  function automatic logic sda_chan(input logic [7:0] b, input logic [1:0] sel);
    logic [3:0] ch;
    ch = b[spm_pkg::CH_SDA0 +: 4];
    return ch[sel];
  endfunction : sda_chan

  function automatic logic is_i2c(input spm_pkg::spm_app_type a);
    return (a == spm_pkg::APP_I2C_RD) || (a == spm_pkg::APP_I2C_WR);
  endfunction : is_i2c

  // stored bytes come out of a registered read, one cycle behind the pointer
  spm_pattern_store u_store (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .we_in(load_we_in),
    .waddr_in(load_addr_in),
    .wdata_in(load_data_in),
    .raddr_in(s_r.ptr),
    .rdata_out(rd_data)
  );

  // core next state: pins, deglitch, divider, sequencer and serial masters
  always_comb begin
    logic start;
    logic adv;
    logic at_end;
    start = 1'b0;
    adv = 1'b0;
    at_end = 1'b0;
    s_nxt = s_r;
    // trigger, hold, long enable and sda pins pass two flops before anything reads them
    s_nxt.trig_s1 = trig_in;
    s_nxt.trig_s2 = s_r.trig_s1;
    s_nxt.hold_s1 = pattern_hold_low_in;
    s_nxt.hold_s2 = s_r.hold_s1;
    s_nxt.len_s1 = long_enable_in;
    s_nxt.len_s2 = s_r.len_s1;
    s_nxt.sda_s1 = sda_in;
    s_nxt.sda_s2 = s_r.sda_s1;

    // trigger counts only after holding its new level for the whole window
    if (s_r.trig_s2 != s_r.trig_clean) begin
      if (s_r.deg_cnt == 5'(spm_pkg::DEGLITCH_CYC - 1)) begin
        s_nxt.trig_clean = s_r.trig_s2;
        s_nxt.deg_cnt = 5'h0;
      end else begin
        s_nxt.deg_cnt = s_r.deg_cnt + 5'h1;
      end
    end else begin
      s_nxt.deg_cnt = 5'h0;
    end
    s_nxt.trig_clean_d = s_r.trig_clean;

    // pattern clock generator, one tick per pattern clock rising edge
    s_nxt.tick = 1'b0;
    if (s_r.div_cnt == 7'(spm_pkg::PAT_DIV_CYC - 1)) begin
      s_nxt.div_cnt = 7'h0;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.div_cnt = s_r.div_cnt + 7'h1;
    end

    // stored byte follows the pointer; chip select history for edge detect
    s_nxt.out_byte = rd_data;
    s_nxt.cs_d = s_r.out_byte[spm_pkg::CH_CS];

    // command sequencer
    unique case (s_r.state)
      spm_pkg::ST_IDLE: begin
        s_nxt.app = spm_pkg::spm_app_type'(app_mode_in);
        if (s_r.app == spm_pkg::APP_LONG) begin
          start = s_r.len_s2;
        end else begin
          start = s_r.trig_clean && !s_r.trig_clean_d;
        end
        if (start) begin
          s_nxt.state = spm_pkg::ST_RUN;
          s_nxt.ptr = 7'h0; // idle keeps the last byte standing
          s_nxt.ack_fail = 1'b0;
          s_nxt.bit_sel = 3'h0;
          s_nxt.byte_pos = 7'h0;
          if (s_r.app == spm_pkg::APP_I2C_RD) begin
            s_nxt.cmp_ok = 1'b1;
            s_nxt.ref_sr = ref_byte_in;
          end
        end
      end
      spm_pkg::ST_RUN: begin
        if (s_r.app == spm_pkg::APP_LONG && !s_r.len_s2) begin
          s_nxt.state = spm_pkg::ST_IDLE;
        end else if (s_r.app == spm_pkg::APP_SPI &&
                     s_r.out_byte[spm_pkg::CH_CS] && !s_r.cs_d) begin
          s_nxt.state = spm_pkg::ST_DONE;
        end else if (s_r.tick) begin
          if (is_i2c(s_r.app) && s_r.out_byte[spm_pkg::CH_ACK] && s_r.sda_s2) begin
            s_nxt.ack_fail = 1'b1;
            s_nxt.state = spm_pkg::ST_DONE;
          end else begin
            if (s_r.app == spm_pkg::APP_I2C_RD && s_r.out_byte[spm_pkg::CH_CMP]) begin
              if (s_r.sda_s2 != s_r.ref_sr[7]) begin
                s_nxt.cmp_ok = 1'b0;
              end
              s_nxt.ref_sr = {s_r.ref_sr[6:0], s_r.ref_sr[7]};
            end
            // long pattern steps a byte after all eight bits went out
            if (s_r.app == spm_pkg::APP_LONG) begin
              s_nxt.bit_sel = s_r.bit_sel + 3'h1;
              adv = (s_r.bit_sel == 3'h7);
              at_end = (s_r.byte_pos == spm_pkg::LAST_ADDR);
            end else begin
              adv = 1'b1;
              at_end = (s_r.ptr == spm_pkg::LAST_ADDR);
            end
            if (adv) begin
              if (at_end) begin
                if (stop_at_end_mode_in) begin
                  s_nxt.state = spm_pkg::ST_DONE;
                  s_nxt.bit_sel = s_r.bit_sel;
                end else begin
                  s_nxt.ptr = 7'h0;
                  s_nxt.byte_pos = 7'h0;
                end
              end else begin
                s_nxt.ptr = s_r.ptr + 7'h1;
                s_nxt.byte_pos = s_r.byte_pos + 7'h1;
              end
            end
          end
        end
      end
      spm_pkg::ST_DONE: begin
        // the last byte stays until the run request goes away
        if (s_r.app == spm_pkg::APP_LONG ? !s_r.len_s2 : !s_r.trig_clean) begin
          s_nxt.state = spm_pkg::ST_IDLE;
        end
      end
      default: begin
        s_nxt.state = spm_pkg::ST_IDLE;
      end
    endcase

    // pattern hold low forces the start location and the initial value
    if (!s_r.hold_s2) begin
      s_nxt.ptr = 7'h0;
      s_nxt.byte_pos = 7'h0;
      s_nxt.bit_sel = 3'h0;
      s_nxt.out_byte = spm_pkg::INIT_BYTE;
      s_nxt.state = spm_pkg::ST_IDLE;
    end

    // output lines: initial value, host virtual bits or pattern byte
    if (!s_r.hold_s2) begin
      s_nxt.bus_byte = spm_pkg::INIT_BYTE;
    end else if (virt_sel_in) begin
      s_nxt.bus_byte = virt_bits_in;
    end else begin
      s_nxt.bus_byte = s_r.out_byte;
    end

    // bit multiplexer for the long pattern
    s_nxt.ser_out = s_r.out_byte[s_r.bit_sel];

    // sda is open drain: pull low when the chosen channel is low
    s_nxt.sda_oe = (s_r.state == spm_pkg::ST_RUN) && is_i2c(s_r.app) &&
                   !sda_chan(s_r.out_byte, mux_select_in);

    // host bits for the chained registers, plus a toggle handshake for the seed
    s_nxt.shr_clr = shr_clear_in;
    s_nxt.shr_go = shr_start_in;
    if (shr_load_in) begin
      s_nxt.seed = shr_seed_in;
      s_nxt.req_tgl = !s_r.req_tgl;
    end

    s_nxt.busy = (s_nxt.state == spm_pkg::ST_RUN); // own flop so the pin has no decode
    if (srst_in) begin
      s_nxt = '0;
      s_nxt.out_byte = spm_pkg::INIT_BYTE;
      s_nxt.bus_byte = spm_pkg::INIT_BYTE;
    end
  end

  always_ff @(posedge clk_in) begin
    s_r <= s_nxt;
  end

  // link side: chained shift registers on the receiver's clock
  always_comb begin
    l_nxt = l_r;
    l_nxt.rst_s1 = srst_in;
    l_nxt.rst_s2 = l_r.rst_s1;
    l_nxt.clr_s1 = s_r.shr_clr;
    l_nxt.clr_s2 = l_r.clr_s1;
    l_nxt.go_s1 = s_r.shr_go;
    l_nxt.go_s2 = l_r.go_s1;
    l_nxt.req_s1 = s_r.req_tgl;
    l_nxt.req_s2 = l_r.req_s1;
    l_nxt.req_s3 = l_r.req_s2;
    if (l_r.clr_s2) begin
      l_nxt.chain = '0;
      l_nxt.phase = 1'b0;
    end else if (l_r.req_s2 != l_r.req_s3) begin
      // seed held still in the core until the toggle has settled here
      l_nxt.chain = s_r.seed;
    end else if (l_r.go_s2) begin
      l_nxt.phase = !l_r.phase;
      // data moves on the falling shift clock, receiver samples on rising
      if (l_r.phase) begin
        for (int k = 0; k < 4; k++) begin
          l_nxt.chain[k] = {l_r.chain[k][6:0], l_r.chain[(k + 3) % 4][7]};
        end
      end
    end
    l_nxt.dout = l_nxt.chain[3][7];
    if (l_r.rst_s2) begin
      l_nxt = '0;
      l_nxt.rst_s1 = srst_in;
      l_nxt.rst_s2 = l_r.rst_s1;
    end
  end

  always_ff @(posedge link_clk_in) begin
    l_r <= l_nxt;
  end

  // every output but sda_out straight from a flop; sda_out is tied low
  assign pattern_byte_out = s_r.bus_byte;
  assign long_serial_out = s_r.ser_out;
  assign sda_out = 1'b0 & s_r.sda_oe;
  assign sda_oe_out = s_r.sda_oe;
  assign busy_out = s_r.busy;
  assign ack_fail_out = s_r.ack_fail;
  assign cmp_ok_out = s_r.cmp_ok;
  assign shr_data_out = l_r.dout;
  assign shr_clk_out = l_r.phase;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);

  chk_hold_init: assert property (!s_r.hold_s2 |=> s_r.bus_byte == spm_pkg::INIT_BYTE)
    else $error("hold low did not show the initial value");

  chk_ptr_home: assert property (!s_r.hold_s2 |=> s_r.ptr == 7'h0)
    else $error("hold low did not return the pointer");

  chk_ptr_step: assert property ((s_r.state == spm_pkg::ST_RUN && s_r.tick && s_r.hold_s2 &&
      s_r.app != spm_pkg::APP_LONG && s_r.ptr < spm_pkg::LAST_ADDR) |=>
      (s_r.ptr == $past(s_r.ptr) + 7'h1 || s_r.state == spm_pkg::ST_DONE))
    else $error("pointer did not advance on a pattern tick");

  chk_wrap_home: assert property ((s_r.state == spm_pkg::ST_RUN && s_r.tick && s_r.hold_s2 &&
      !stop_at_end_mode_in && s_r.app == spm_pkg::APP_I2C_WR &&
      !(s_r.out_byte[spm_pkg::CH_ACK] && s_r.sda_s2) && s_r.ptr == spm_pkg::LAST_ADDR) |=>
      s_r.ptr == 7'h0)
    else $error("wrap mode did not return to the first byte");

  chk_stop_hold: assert property ((s_r.state == spm_pkg::ST_DONE && s_r.hold_s2) |=>
      $stable(s_r.ptr))
    else $error("stopped sequencer moved its pointer");

  chk_tick_rate: assert property (s_r.tick |=> !s_r.tick [*8])
    else $error("pattern clock too fast");

  chk_ack_stop: assert property ((s_r.state == spm_pkg::ST_RUN && s_r.tick && s_r.hold_s2 &&
      is_i2c(s_r.app) && s_r.out_byte[spm_pkg::CH_ACK] && s_r.sda_s2) |=>
      (s_r.ack_fail && s_r.state == spm_pkg::ST_DONE ##1 !s_r.sda_oe))
    else $error("missing acknowledge did not stop the command");

  chk_cs_stop: assert property ((s_r.state == spm_pkg::ST_RUN && s_r.hold_s2 &&
      s_r.app == spm_pkg::APP_SPI && s_r.out_byte[spm_pkg::CH_CS] && !s_r.cs_d) |=>
      !busy_out)
    else $error("chip select rise did not stop the run");

  chk_bit_sel: assert property ((s_r.state == spm_pkg::ST_RUN && s_r.tick && s_r.hold_s2 &&
      s_r.app == spm_pkg::APP_LONG && s_r.len_s2 && s_r.bit_sel != 3'h7) |=>
      s_r.bit_sel == $past(s_r.bit_sel) + 3'h1)
    else $error("bit select did not step");

  chk_shr_clear: assert property (@(posedge link_clk_in) disable iff (l_r.rst_s2)
      l_r.clr_s2 |=> (l_r.chain == '0 && !l_r.phase))
    else $error("chained registers not cleared");

  chk_shr_recirc: assert property (@(posedge link_clk_in) disable iff (l_r.rst_s2)
      (l_r.go_s2 && !l_r.clr_s2 && l_r.phase && l_r.req_s2 == l_r.req_s3) |=>
      l_r.chain[0][0] == $past(l_r.chain[3][7]))
    else $error("last register did not feed the first");
endmodule : spm_serial_master

//--- pkg/spm_pkg.sv
package spm_pkg;
  // system clock and the fastest allowed pattern clock
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned PAT_CLK_MIN_NS = 1000;
  // least period rounds up, so the pattern clock never exceeds its limit
  localparam int unsigned PAT_DIV_CYC = (PAT_CLK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // trigger must stay at a new level this long before it counts
  localparam int unsigned DEGLITCH_NS = 200;
  localparam int unsigned DEGLITCH_CYC = (DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // pattern store
  localparam int unsigned STORE_DEPTH = 92;
  localparam int unsigned ADDR_W = 7;
  localparam logic [6:0] LAST_ADDR = 7'(STORE_DEPTH - 1);
  localparam logic [7:0] INIT_BYTE = 8'h00;

  // channel positions inside a stored byte, i2c applications
  localparam int unsigned CH_SCL = 0;
  localparam int unsigned CH_SDA0 = 1;
  localparam int unsigned CH_ACK = 5;
  localparam int unsigned CH_CMP = 6;
  // channel positions, spi application
  localparam int unsigned CH_SCK = 0;
  localparam int unsigned CH_MOSI = 1;
  localparam int unsigned CH_CS = 2;

  typedef enum logic [1:0] {
    APP_LONG = 2'h0,
    APP_I2C_RD = 2'h1,
    APP_I2C_WR = 2'h2,
    APP_SPI = 2'h3
  } spm_app_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_RUN = 2'h1,
    ST_DONE = 2'h2
  } spm_state_type;
endpackage : spm_pkg

//--- design/spm_pattern_store.sv
// byte store filled from the nonvolatile image; read data is registered
module spm_pattern_store (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic we_in,
  input wire logic [6:0] waddr_in,
  input wire logic [7:0] wdata_in,
  input wire logic [6:0] raddr_in,
  output logic [7:0] rdata_out
);
  logic [7:0] mem [spm_pkg::STORE_DEPTH];

  // image load port; addresses past the last byte are dropped
  always_ff @(posedge clk_in) begin
    if (we_in && (waddr_in <= spm_pkg::LAST_ADDR)) begin
      mem[waddr_in] <= wdata_in;
    end
  end

  // registered read, out of range reads give the initial value
  always_ff @(posedge clk_in) begin
    if (srst_in || (raddr_in > spm_pkg::LAST_ADDR)) begin
      rdata_out <= spm_pkg::INIT_BYTE;
    end else begin
      rdata_out <= mem[raddr_in];
    end
  end
endmodule : spm_pattern_store

//--- bench/spm_i2c_slave_model.sv
// slave on the far side of sda; follows the channel bits on the shared output lines
module spm_i2c_slave_model (
  input wire logic [7:0] pattern_byte_in,
  input wire logic sda_oe_in,
  input wire logic nack_in,
  input wire logic corrupt_in,
  input wire logic [7:0] ref_byte_in,
  output logic sda_out
);
  timeunit 1ns;
  timeprecision 100ps;
  int bit_idx = 0;
  logic drive_low;
  // each new byte with the compare strobe is one more bit of read data
  always @(pattern_byte_in) begin
    if (pattern_byte_in[spm_pkg::CH_CMP]) bit_idx = bit_idx + 1;
    else bit_idx = 0;
  end
  // acknowledge unless told to refuse; read data goes msb first and wraps every 8
  always_comb begin
    drive_low = 1'b0;
    if (pattern_byte_in[spm_pkg::CH_ACK]) drive_low = ~nack_in;
    else if (bit_idx > 0) drive_low = ~(ref_byte_in[7 - ((bit_idx - 1) % 8)] ^ corrupt_in);
  end
  // open drain with a pull-up, so a released line reads high and never keeps old data
  assign sda_out = ~(sda_oe_in | drive_low);
endmodule : spm_i2c_slave_model

//--- bench/spm_serial_master_test.sv
module spm_serial_master_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, srst = 1'b1, link_clk = 1'b0, trig = 1'b0, hold_low = 1'b1;
  logic long_en = 1'b0, stop_mode = 1'b1, virt_sel = 1'b0, load_we = 1'b0, sda;
  logic shr_clear = 1'b0, shr_start = 1'b0, shr_load = 1'b0, nack = 1'b0, corrupt = 1'b0;
  logic [1:0] app_mode = 2'h0, mux_sel = 2'h3;
  logic [7:0] ref_byte = 8'ha5, virt_bits = 8'h00, load_data = 8'h00, b;
  logic [6:0] load_addr = 7'h00;
  logic [31:0] seed = 32'hc3a5_1e69;
  logic [7:0] pattern_byte;
  logic long_serial, sda_drv, sda_oe, busy, ack_fail, cmp_ok, shr_data, shr_clk;
  logic shr_prev = 1'b0;
  int failures = 0, total_checks = 0;
  int n_cyc;

  // link clock has its own rate and an odd start so its phase is unrelated
  initial begin
    forever #5 clk = ~clk;
  end
  initial begin
    #3;
    forever #62.5 link_clk = ~link_clk;
  end
  always @(posedge clk) shr_prev <= shr_clk;

  spm_serial_master DUT (
    .clk_in(clk), .srst_in(srst), .link_clk_in(link_clk), .trig_in(trig),
    .pattern_hold_low_in(hold_low), .long_enable_in(long_en), .app_mode_in(app_mode),
    .stop_at_end_mode_in(stop_mode), .mux_select_in(mux_sel), .ref_byte_in(ref_byte),
    .virt_sel_in(virt_sel), .virt_bits_in(virt_bits), .load_we_in(load_we),
    .load_addr_in(load_addr), .load_data_in(load_data), .sda_in(sda),
    .shr_clear_in(shr_clear), .shr_start_in(shr_start), .shr_load_in(shr_load),
    .shr_seed_in(seed), .pattern_byte_out(pattern_byte), .long_serial_out(long_serial),
    .sda_out(sda_drv), .sda_oe_out(sda_oe), .busy_out(busy), .ack_fail_out(ack_fail),
    .cmp_ok_out(cmp_ok), .shr_data_out(shr_data), .shr_clk_out(shr_clk)
  );
  spm_i2c_slave_model slave (
    .pattern_byte_in(pattern_byte), .sda_oe_in(sda_oe), .nack_in(nack),
    .corrupt_in(corrupt), .ref_byte_in(ref_byte), .sda_out(sda)
  );

  // image bytes are all distinct; sda channel bit4 is released from byte 16 on
  function automatic logic [7:0] img(input int i);
    logic [6:0] a;
    a = 7'(i);
    return {a[4], a[6:5], a[4] | (a[6:5] != 2'h0), a[3:0]};
  endfunction : img

  task automatic stop_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check_byte

  task automatic check_bit(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // bounded wait for a byte on the output lines; running out ends the run
  task automatic wait_byte(input logic [7:0] exp, input int bound);
    int n;
    n = 0;
    while (pattern_byte !== exp && n < bound) begin
      @(posedge clk);
      n++;
    end
    check_byte("pattern byte", exp, pattern_byte);
    if (n == bound) stop_test();
  endtask : wait_byte

  // trigger stays up until the run is seen, then drops so done can return to idle
  task automatic start_run(input logic [1:0] mode);
    int n;
    n = 0;
    app_mode <= mode;
    trig <= 1'b1;
    while (busy !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    check_bit("busy at start", 1'b1, busy);
    if (n == 100) stop_test();
    trig <= 1'b0;
  endtask : start_run

  task automatic shr_edge();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!(shr_clk === 1'b1 && shr_prev === 1'b0) && n < 200);
    check_bit("shift clock rise", 1'b1, shr_clk);
    if (n == 200) stop_test();
  endtask : shr_edge

  // main sequence; reset is held long enough for the link side to see it too
  initial begin
    cyc(40);
    srst <= 1'b0;
    cyc(2);
    check_byte("reset byte", 8'h00, pattern_byte);
    check_bit("reset busy", 1'b0, busy);
    for (int i = 0; i < 92; i++) begin
      load_we <= 1'b1;
      load_addr <= 7'(i);
      load_data <= img(i);
      cyc(1);
    end
    load_we <= 1'b0;
    app_mode <= 2'h2;
    trig <= 1'b1;
    cyc(10);
    trig <= 1'b0;
    cyc(60);
    check_bit("busy after glitch", 1'b0, busy);
    $display("test deglitch done");
    start_run(2'h2);
    for (int i = 0; i < 92; i++) begin
      wait_byte(img(i), 300);
      if (i < 32) begin
        b = img(i);
        mux_sel <= 2'(i);
        cyc(50);
        check_bit("sda enable", ~b[1 + i % 4], sda_oe);
      end
    end
    check_bit("sda level", 1'b0, sda_drv);
    mux_sel <= 2'h3;
    cyc(200);
    check_byte("held last byte", img(91), pattern_byte);
    check_bit("busy at end", 1'b0, busy);
    check_bit("ack fail", 1'b0, ack_fail);
    $display("test write stop done");
    stop_mode <= 1'b0;
    start_run(2'h2);
    wait_byte(img(50), 6000);
    n_cyc = 0;
    while (pattern_byte === img(50) && n_cyc < 200) begin
      cyc(1);
      n_cyc++;
    end
    check_byte("byte period", 8'(spm_pkg::PAT_DIV_CYC), 8'(n_cyc));
    wait_byte(img(91), 5000);
    wait_byte(img(5), 800);
    hold_low <= 1'b0;
    cyc(10);
    check_byte("hold byte", 8'h00, pattern_byte);
    check_bit("hold busy", 1'b0, busy);
    hold_low <= 1'b1;
    cyc(5);
    start_run(2'h2);
    wait_byte(img(1), 250);
    hold_low <= 1'b0;
    cyc(5);
    hold_low <= 1'b1;
    stop_mode <= 1'b1;
    cyc(5);
    $display("test wrap and hold done");
    nack <= 1'b1;
    start_run(2'h2);
    wait_byte(img(32), 4000);
    // the acknowledge is sampled at the tick that ends byte 32
    cyc(120);
    check_bit("nack fail", 1'b1, ack_fail);
    check_bit("nack busy", 1'b0, busy);
    check_bit("nack release", 1'b0, sda_oe);
    nack <= 1'b0;
    $display("test nack done");
    for (int r = 0; r < 2; r++) begin
      corrupt <= 1'(r);
      start_run(2'h1);
      // the last byte of the previous run still stands, so pass the middle first
      wait_byte(img(50), 6000);
      wait_byte(img(91), 5000);
      cyc(120);
      check_bit("compare", 1'(1 - r), cmp_ok);
      check_bit("ack fail cleared", 1'b0, ack_fail);
    end
    corrupt <= 1'b0;
    $display("test read done");
    start_run(2'h3);
    wait_byte(img(4), 1000);
    cyc(10);
    check_bit("spi stop", 1'b0, busy);
    $display("test spi done");
    app_mode <= 2'h0;
    long_en <= 1'b1;
    wait_byte(img(1), 1500);
    b = img(1);
    cyc(50);
    for (int k = 0; k < 8; k++) begin
      check_bit("serial bit", b[k], long_serial);
      cyc(100);
    end
    long_en <= 1'b0;
    cyc(30);
    check_bit("long stop", 1'b0, busy);
    $display("test long done");
    virt_bits <= 8'h5a;
    virt_sel <= 1'b1;
    cyc(5);
    check_byte("virtual bits", 8'h5a, pattern_byte);
    virt_sel <= 1'b0;
    $display("test virtual done");
    shr_clear <= 1'b1;
    cyc(30);
    shr_clear <= 1'b0;
    shr_load <= 1'b1;
    cyc(1);
    shr_load <= 1'b0;
    cyc(100);
    shr_start <= 1'b1;
    for (int k = 0; k < 40; k++) begin
      shr_edge();
      check_bit("chained bit", seed[31 - k % 32], shr_data);
    end
    shr_clear <= 1'b1;
    cyc(300);
    check_bit("chained clear", 1'b0, shr_data);
    $display("test chained done");
    stop_test();
  end
endmodule : spm_serial_master_test
